// >>> design/qld_lo_sync.sv
`timescale 1ns/1ps
`default_nettype none

module qld_lo_sync #(
  parameter int NUM_CH = qld_pkg::NUM_CH,
  parameter qld_pkg::qld_div_state_t START_STATE = qld_pkg::DIV_P0,
  localparam int SUM_W = $clog2(NUM_CH + 1)
) (
  input wire logic CLK_I, // lo_times_four_clock
  input wire logic RESETN_I, // power-on reset, active low
  input wire logic DIV_RESET_I, // divider reset, active high
  input wire logic [NUM_CH*qld_pkg::CFG_W-1:0] CHAN_CFG_I, // one config byte per channel
  output logic LO_I_O, // shared in-phase lo
  output logic LO_Q_O, // shared quadrature lo
  output qld_pkg::qld_div_state_t LO_QUAD_O, // shared divider phase state
  output logic DIV_RUN_O, // divider running
  output qld_pkg::qld_chan_lo_t [NUM_CH-1:0] CHAN_LO_O, // rotated lo per channel
  output logic [SUM_W-1:0] SUM_I_O, // count of enabled channels with I high
  output logic [SUM_W-1:0] SUM_Q_O // count of enabled channels with Q high
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic qld_pkg::qld_chan_cfg_t unpack_cfg(input logic [qld_pkg::CFG_W-1:0] b);
    qld_pkg::qld_chan_cfg_t c;
    c.enable = b[qld_pkg::CFG_EN_BIT];
    c.phase = b[qld_pkg::CFG_PH_LSB +: qld_pkg::PHASE_W];
    return c;
  endfunction : unpack_cfg

  // lo phase in 22.5 degree steps: quarter state plus the channel code
  function automatic logic [qld_pkg::PHASE_W-1:0] rotate(
    input qld_pkg::qld_div_state_t quad,
    input logic [qld_pkg::PHASE_W-1:0] code
  );
    logic [2*qld_pkg::PHASE_W-1:0] prod;
    prod = {{qld_pkg::PHASE_W{1'b0}}, 2'b00, quad} * {{qld_pkg::PHASE_W{1'b0}}, qld_pkg::QUAD_STEPS};
    return prod[qld_pkg::PHASE_W-1:0] + code;
  endfunction : rotate

  // I high over the first half turn, Q a quarter turn later
  function automatic logic half_low(input logic [qld_pkg::PHASE_W-1:0] ph);
    return ~ph[qld_pkg::HALF_TURN_BIT];
  endfunction : half_low

  //////////////////////////////////////////////////////////////////////////////
  // single shared divider

  logic div_i;
  logic div_q;
  qld_pkg::qld_div_state_t div_quad;
  logic div_run;

  qld_div4 #(
    .START_STATE(START_STATE)
  ) u_div (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .div_rst_i(DIV_RESET_I),
    .lo_i_o(div_i),
    .lo_q_o(div_q),
    .quad_o(div_quad),
    .run_o(div_run)
  );

  assign LO_I_O = div_i;
  assign LO_Q_O = div_q;
  assign LO_QUAD_O = div_quad;
  assign DIV_RUN_O = div_run;

  //////////////////////////////////////////////////////////////////////////////
  // channel configuration, taken only at an lo cycle boundary or while the divider is not running

  logic cfg_take;
  qld_pkg::qld_chan_cfg_t [NUM_CH-1:0] cfg;

  // changing the code mid-cycle would glitch the rotated lo
  assign cfg_take = !div_run || (div_quad == qld_pkg::DIV_P270);

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cfg <= {NUM_CH{qld_pkg::CFG_RESET}};
    end else if (cfg_take) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        cfg[ch] <= unpack_cfg(CHAN_CFG_I[ch*qld_pkg::CFG_W +: qld_pkg::CFG_W]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel rotated lo, all fed from the one shared divider state

  qld_pkg::qld_chan_lo_t [NUM_CH-1:0] next_lo;

  always_comb begin
    logic [qld_pkg::PHASE_W-1:0] ph;
    ph = qld_pkg::PHASE_ZERO;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      ph = rotate(div_quad, cfg[ch].phase);
      if (cfg[ch].enable && div_run) begin
        next_lo[ch].phase = ph;
        next_lo[ch].lo_i = half_low(ph);
        next_lo[ch].lo_q = half_low(ph - qld_pkg::QUAD_STEPS);
      end else begin
        next_lo[ch] = qld_pkg::LO_IDLE;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CHAN_LO_O <= {NUM_CH{qld_pkg::LO_IDLE}};
    end else begin
      CHAN_LO_O <= next_lo;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // current-summed I and Q of the enabled channels

  logic [SUM_W-1:0] next_sum_i;
  logic [SUM_W-1:0] next_sum_q;

  always_comb begin
    next_sum_i = '0;
    next_sum_q = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_sum_i = next_sum_i + SUM_W'(next_lo[ch].lo_i);
      next_sum_q = next_sum_q + SUM_W'(next_lo[ch].lo_q);
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SUM_I_O <= '0;
      SUM_Q_O <= '0;
    end else begin
      SUM_I_O <= next_sum_i;
      SUM_Q_O <= next_sum_q;
    end
  end

endmodule : qld_lo_sync

`default_nettype wire

// >>> design/qld_pkg.sv
package qld_pkg;

  // channel count and per-channel configuration byte layout
  localparam int NUM_CH = 8;
  localparam int CFG_W = 8;
  localparam int CFG_EN_BIT = 4;
  localparam int CFG_PH_LSB = 0;
  localparam int PHASE_W = 4;

  // rotation arithmetic in 22.5 degree steps
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;
  localparam logic [PHASE_W-1:0] QUAD_STEPS = 4'h4;
  localparam int HALF_TURN_BIT = PHASE_W - 1;

  // timing of the lo_times_four_clock and of the divider reset pulse
  localparam int CLK_PERIOD_NS = 40;
  localparam int DIV_RST_MIN_NS = 20;
  localparam int DIV_RST_MIN_CYC_RAW = (DIV_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_RST_MIN_CYC = (DIV_RST_MIN_CYC_RAW < 1) ? 1 : DIV_RST_MIN_CYC_RAW;

  // divide-by-four phase states, a quarter lo cycle apart
  typedef enum logic [1:0] {
    DIV_P0,
    DIV_P90,
    DIV_P180,
    DIV_P270
  } qld_div_state_t;

  typedef struct packed {
    logic enable;
    logic [PHASE_W-1:0] phase;
  } qld_chan_cfg_t;

  typedef struct packed {
    logic lo_i;
    logic lo_q;
    logic [PHASE_W-1:0] phase;
  } qld_chan_lo_t;

  localparam qld_chan_cfg_t CFG_RESET = '{enable: 1'b0, phase: PHASE_ZERO};
  localparam qld_chan_lo_t LO_IDLE = '{lo_i: 1'b0, lo_q: 1'b0, phase: PHASE_ZERO};

endpackage : qld_pkg

// >>> design/qld_div4.sv
`timescale 1ns/1ps
`default_nettype none

module qld_div4 #(
  parameter qld_pkg::qld_div_state_t START_STATE = qld_pkg::DIV_P0
) (
  input wire logic clk_i, // lo_times_four_clock
  input wire logic rst_n_i, // power-on reset, active low
  input wire logic div_rst_i, // divider reset, active high, asynchronous
  output logic lo_i_o, // in-phase lo, reclocked
  output logic lo_q_o, // quadrature lo, reclocked
  output qld_pkg::qld_div_state_t quad_o, // phase state aligned with lo_i_o/lo_q_o
  output logic run_o // divider running
);

  logic hold_n;
  logic pwr_load;
  qld_pkg::qld_div_state_t state;

  assign hold_n = rst_n_i & ~div_rst_i;

  //////////////////////////////////////////////////////////////////////////////
  // power-up may leave the divider in any quarter state; a divider reset wins

  always_ff @(posedge clk_i or negedge rst_n_i or posedge div_rst_i) begin
    if (!rst_n_i) begin
      pwr_load <= 1'b1;
    end else if (div_rst_i) begin
      pwr_load <= 1'b0;
    end else begin
      pwr_load <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // divide by four: one state step per lo_times_four_clock edge

  always_ff @(posedge clk_i or negedge hold_n) begin
    if (!hold_n) begin
      state <= qld_pkg::DIV_P0;
    end else if (pwr_load) begin
      state <= START_STATE;
    end else begin
      state <= qld_pkg::qld_div_state_t'(state + 2'd1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // final flip-flops reclocked by the fast clock: 50% duty, fixed 90 degrees

  always_ff @(posedge clk_i or negedge hold_n) begin
    if (!hold_n) begin
      lo_i_o <= 1'b0;
      lo_q_o <= 1'b0;
      quad_o <= qld_pkg::DIV_P0;
    end else if (pwr_load) begin
      // stay quiet until the power-up quarter is loaded, so no false quarter shows
      lo_i_o <= 1'b0;
      lo_q_o <= 1'b0;
      quad_o <= qld_pkg::DIV_P0;
    end else begin
      lo_i_o <= (state == qld_pkg::DIV_P0) || (state == qld_pkg::DIV_P90);
      lo_q_o <= (state == qld_pkg::DIV_P90) || (state == qld_pkg::DIV_P180);
      quad_o <= state;
    end
  end

  always_ff @(posedge clk_i or negedge hold_n) begin
    if (!hold_n) begin
      run_o <= 1'b0;
    end else if (pwr_load) begin
      run_o <= 1'b0;
    end else begin
      run_o <= 1'b1;
    end
  end

endmodule : qld_div4

`default_nettype wire

// >>> bench/qld_lo_sync_checker.sv
`timescale 1ns/1ps
`default_nettype none

module qld_lo_sync_checker #(
  parameter int NUM_CH = qld_pkg::NUM_CH,
  localparam int SUM_W = $clog2(NUM_CH + 1)
) (
  input wire logic CLK_I, // clock
  input wire logic RESETN_I, // reset, active low
  input wire logic DIV_RESET_I, // divider reset
  input wire logic [NUM_CH*qld_pkg::CFG_W-1:0] CHAN_CFG_I, // config
  input wire logic LO_I_O, // i lo
  input wire logic LO_Q_O, // q lo
  input wire qld_pkg::qld_div_state_t LO_QUAD_O, // state
  input wire logic DIV_RUN_O, // running
  input wire qld_pkg::qld_chan_lo_t [NUM_CH-1:0] CHAN_LO_O, // channel lo
  input wire logic [SUM_W-1:0] SUM_I_O, // i sum
  input wire logic [SUM_W-1:0] SUM_Q_O // q sum
);
  logic [NUM_CH-1:0] li;
  logic [NUM_CH-1:0] lq;
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      li[n] = CHAN_LO_O[n].lo_i;
      lq[n] = CHAN_LO_O[n].lo_q;
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  ////////////////////////////////////////////////////////////////////////////////
  quad_step_a: assert property (disable iff (!RESETN_I || DIV_RESET_I)
    DIV_RUN_O |=> LO_QUAD_O == 2'($past(LO_QUAD_O) + 2'h1)) else $error("quad step wrong");
  quad_decode_a: assert property (DIV_RUN_O |-> LO_I_O == !LO_QUAD_O[1] &&
    LO_Q_O == (LO_QUAD_O[1] ^ LO_QUAD_O[0])) else $error("i/q decode wrong");
  hold_known_a: assert property (DIV_RESET_I |-> !DIV_RUN_O && !LO_I_O &&
    !LO_Q_O && LO_QUAD_O == qld_pkg::DIV_P0) else $error("held state wrong");
  restart_edge_a: assert property ($fell(DIV_RESET_I) |-> !DIV_RUN_O ##1 DIV_RUN_O &&
    LO_QUAD_O == qld_pkg::DIV_P0 ##1 LO_QUAD_O == qld_pkg::DIV_P90) else $error("restart wrong");
  duty_half_a: assert property (disable iff (!RESETN_I || DIV_RESET_I)
    $rose(LO_I_O) && $past(DIV_RUN_O) |=> LO_I_O ##1 !LO_I_O) else $error("duty wrong");
  ch_phase_a: assert property ($stable(CHAN_CFG_I)[*8] ##0 CHAN_CFG_I[4] &&
    DIV_RUN_O && $past(DIV_RUN_O) |-> CHAN_LO_O[0].phase ==
    {$past(LO_QUAD_O), 2'b00} + CHAN_CFG_I[3:0]) else $error("rotation wrong");
  ch_bits_a: assert property (CHAN_LO_O[0] != '0 |-> CHAN_LO_O[0].lo_i ==
    !CHAN_LO_O[0].phase[3] && CHAN_LO_O[0].lo_q == (4'(CHAN_LO_O[0].phase + 4'hc) < 4'h8))
    else $error("channel lo wrong");
  ch_off_a: assert property ($stable(CHAN_CFG_I)[*8] ##0 !CHAN_CFG_I[4] |->
    CHAN_LO_O[0] == '0) else $error("disabled channel active");
  sum_count_a: assert property (disable iff (!RESETN_I || DIV_RESET_I)
    $past(DIV_RUN_O) |-> SUM_I_O == SUM_W'($countones(li)) &&
    SUM_Q_O == SUM_W'($countones(lq))) else $error("sum wrong");
endmodule : qld_lo_sync_checker

bind qld_lo_sync qld_lo_sync_checker #(.NUM_CH(NUM_CH)) i_chk (.CLK_I(CLK_I),
  .RESETN_I(RESETN_I), .DIV_RESET_I(DIV_RESET_I), .CHAN_CFG_I(CHAN_CFG_I), .LO_I_O(LO_I_O),
  .LO_Q_O(LO_Q_O), .LO_QUAD_O(LO_QUAD_O), .DIV_RUN_O(DIV_RUN_O), .CHAN_LO_O(CHAN_LO_O),
  .SUM_I_O(SUM_I_O), .SUM_Q_O(SUM_Q_O));
`default_nettype wire

// >>> bench/qld_lo_src.sv
`timescale 1ns/1ps
`default_nettype none

module qld_lo_src (
  output logic clk_o, // lo_times_four_clock
  output logic div_rst_o // divider reset, active high
);
  initial begin
    clk_o = 1'b0;
    div_rst_o = 1'b0;
    forever #20 clk_o = ~clk_o;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // moves only on falling edges, half a period clear of the sampling edge
  task automatic rst_on();
    @(negedge clk_o);
    div_rst_o = 1'b1;
  endtask : rst_on

  task automatic rst_off(input int n);
    repeat (n) @(negedge clk_o);
    div_rst_o = 1'b0;
  endtask : rst_off
endmodule : qld_lo_src
`default_nettype wire

// >>> bench/qld_lo_sync_tb.sv
`timescale 1ns/1ps
`default_nettype none

module qld_lo_sync_tb;
  localparam int N = qld_pkg::NUM_CH;
  logic CLK_I;
  logic RESETN_I;
  logic DIV_RESET_I;
  logic [N*qld_pkg::CFG_W-1:0] CHAN_CFG_I;
  logic LO_I_O;
  logic LO_Q_O;
  qld_pkg::qld_div_state_t LO_QUAD_O;
  logic DIV_RUN_O;
  qld_pkg::qld_chan_lo_t [N-1:0] CHAN_LO_O;
  logic [$clog2(N+1)-1:0] SUM_I_O;
  logic [$clog2(N+1)-1:0] SUM_Q_O;
  int seed = 6;
  int n_fail = 0;
  int n_checks = 0;
  logic cen[N];
  logic [3:0] cph[N];

  qld_lo_src i_src (.clk_o(CLK_I), .div_rst_o(DIV_RESET_I));
  qld_lo_sync #(.START_STATE(qld_pkg::DIV_P180)) i_dut (.CLK_I(CLK_I),
    .RESETN_I(RESETN_I), .DIV_RESET_I(DIV_RESET_I), .CHAN_CFG_I(CHAN_CFG_I), .LO_I_O(LO_I_O),
    .LO_Q_O(LO_Q_O), .LO_QUAD_O(LO_QUAD_O), .DIV_RUN_O(DIV_RUN_O), .CHAN_LO_O(CHAN_LO_O),
    .SUM_I_O(SUM_I_O), .SUM_Q_O(SUM_Q_O));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // reference lo of one channel for a given divider quarter
  function automatic logic [5:0] exp_ch(int n, int qd);
    logic [3:0] ph;
    logic [3:0] pq;
    ph = 4'(4 * qd) + cph[n];
    pq = ph - 4'h4;
    return cen[n] ? {~ph[3], ~pq[3], ph} : 6'h0;
  endfunction : exp_ch

  function automatic int exp_sum(int qd, int b);
    exp_sum = 0;
    for (int n = 0; n < N; n++) exp_sum += int'(exp_ch(n, qd) >> b) & 1;
  endfunction : exp_sum
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end

  initial begin
    int r;
    int q;
    RESETN_I = 1'b0;
    CHAN_CFG_I = '0;
    repeat (6) @(posedge CLK_I);
    #1 RESETN_I = 1'b1;
    @(posedge CLK_I);
    #2 chk(8'({DIV_RUN_O, LO_QUAD_O, LO_I_O, LO_Q_O}), 8'h0);
    @(posedge CLK_I);
    #2 chk(8'({DIV_RUN_O, LO_QUAD_O, LO_I_O, LO_Q_O}), 8'h19);
    repeat (6) @(posedge CLK_I);
    // pass 0: equal codes, pass 1: 0/2/4/6.. steps, then random
    for (int it = 0; it < 6; it++) begin
      @(posedge CLK_I);
      #1;
      for (int n = 0; n < N; n++) begin
        r = $random(seed);
        cen[n] = (it < 2) ? 1'b1 : r[4];
        cph[n] = (it == 0) ? 4'h0 : (it == 1) ? 4'(2 * n) : r[3:0];
        CHAN_CFG_I[8*n +: 8] = {r[7:5], cen[n], cph[n]};
      end
      i_src.rst_on();
      #1 chk(8'({DIV_RUN_O, LO_I_O, LO_Q_O, LO_QUAD_O}), 8'h0);
      r = $random(seed);
      i_src.rst_off(1 + (r & 3));
      for (int j = 0; j < 14; j++) begin
        @(posedge CLK_I);
        q = j % 4;
        #2 chk(8'({DIV_RUN_O, LO_QUAD_O, LO_I_O, LO_Q_O}),
          8'({1'b1, 2'(q), q < 2, q == 1 || q == 2}));
        for (int n = 0; n < N && j >= 2; n++) chk(8'(CHAN_LO_O[n]), 8'(exp_ch(n, (j - 1) % 4)));
        if (j >= 2) begin
          chk(8'(SUM_I_O), 8'(exp_sum((j - 1) % 4, 5)));
          chk(8'(SUM_Q_O), 8'(exp_sum((j - 1) % 4, 4)));
        end
      end
    end
    stop_test();
  end
endmodule : qld_lo_sync_tb
`default_nettype wire
